// File: rtl/lbi_pkg.sv
// Package: constants and carrier types for the LED and buzzer status indicator
package lbi_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int TONE_HZ = 2000;
    localparam int CHIRP_MS = 400;
    localparam int GAP_MS = 800;
    localparam int PHASE_S = 30;
    localparam int CHIRP_LATENCY_MS = 500;
    localparam int HALF_TONE_CYC = CLK_HZ / (TONE_HZ * 2);
    localparam int CHIRP_CYC = CLK_HZ / 1000 * CHIRP_MS;
    localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
    localparam int PHASE_CYC = CLK_HZ * PHASE_S;
    localparam int SLOW_BLINK_CYC = 10000000;
    localparam int FAST_BLINK_CYC = 2500000;
    localparam int CNT_W = 30;

    // ------------------------------------------------------------
    // Option decode
    // ------------------------------------------------------------
    localparam int OPT_W = 4;
    localparam logic [3:0] OPT_FIRST_DARK = 4'h6;
    localparam logic [3:0] OPT_RESET = 4'h1;

    // ------------------------------------------------------------
    // Operational states and carrier
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        OP_STANDBY = 3'b000,
        OP_TRANSFER = 3'b001,
        OP_COMPLETE = 3'b010,
        OP_FAULT = 3'b011,
        OP_FOREIGN_WARN = 3'b100
    } lbi_op_t;

    typedef struct packed
    {
        logic green_drive;
        logic red_drive;
    } lbi_pins_t;

endpackage

// File: rtl/lbi_indicator.sv
// Module: LED and buzzer status indicator driving two open-drain pins
`timescale 1ns/1ps
`default_nettype none
module lbi_indicator
    import lbi_pkg::*;
#(
    parameter int SLOW_HALF = SLOW_BLINK_CYC,
    parameter int FAST_HALF = FAST_BLINK_CYC,
    parameter int CHIRP_LEN = CHIRP_CYC,
    parameter int GAP_LEN = GAP_CYC,
    parameter int PHASE_LEN = PHASE_CYC,
    parameter int TONE_HALF = HALF_TONE_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire lbi_op_t op_state,
    input wire logic [3:0] option_code,
    input wire logic option_valid,
    input wire logic [1:0] adc_route_sel,
    output logic green_indicator_pin_o,
    output logic green_indicator_pin_oe_n,
    output logic red_indicator_buzzer_pin_o,
    output logic red_indicator_buzzer_pin_oe_n,
    output logic green_adc_route,
    output logic red_adc_route,
    output logic [3:0] option_latched,
    output logic option_done
);

    // ------------------------------------------------------------
    // Option latch
    // ------------------------------------------------------------
    // The converter result arrives from logic on this clock, so no synchroniser
    logic [3:0] opt_ff, nxt_opt;
    logic done_ff, nxt_done;

    always_comb
    begin
        nxt_opt = opt_ff;
        nxt_done = done_ff;
        if (option_valid && !done_ff)
        begin
            nxt_opt = option_code;
            nxt_done = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            opt_ff <= OPT_RESET;
            done_ff <= 1'b0;
        end
        else
        begin
            opt_ff <= nxt_opt;
            done_ff <= nxt_done;
        end
    end

    // ------------------------------------------------------------
    // Blink, tone and pattern timers
    // ------------------------------------------------------------
    logic [CNT_W-1:0] slow_cnt_ff, nxt_slow_cnt, fast_cnt_ff, nxt_fast_cnt;
    logic slow_ff, nxt_slow, fast_ff, nxt_fast;
    logic [CNT_W-1:0] tone_cnt_ff, nxt_tone_cnt;
    logic tone_ff, nxt_tone;
    logic [CNT_W-1:0] chirp_cnt_ff, nxt_chirp_cnt;
    logic [CNT_W-1:0] beep_cnt_ff, nxt_beep_cnt;
    logic [CNT_W-1:0] phase_cnt_ff, nxt_phase_cnt;
    logic quiet_ff, nxt_quiet;
    logic beep_on_ff, nxt_beep_on;
    lbi_op_t prev_ff, nxt_prev;
    logic in_transfer, in_foreign, chirping, foreign_tone;

    assign in_transfer = (op_state == OP_TRANSFER);
    assign in_foreign = (op_state == OP_FOREIGN_WARN);
    assign chirping = (chirp_cnt_ff != '0);
    assign foreign_tone = in_foreign && !quiet_ff && beep_on_ff;

    always_comb
    begin
        // Blink counters run freely; the slight phase offset is harmless
        nxt_slow_cnt = slow_cnt_ff + 1'b1;
        nxt_slow = slow_ff;
        if (slow_cnt_ff >= CNT_W'(SLOW_HALF - 1))
        begin
            nxt_slow_cnt = '0;
            nxt_slow = !slow_ff;
        end
        nxt_fast_cnt = fast_cnt_ff + 1'b1;
        nxt_fast = fast_ff;
        if (fast_cnt_ff >= CNT_W'(FAST_HALF - 1))
        begin
            nxt_fast_cnt = '0;
            nxt_fast = !fast_ff;
        end
        nxt_tone_cnt = tone_cnt_ff + 1'b1;
        nxt_tone = tone_ff;
        if (tone_cnt_ff >= CNT_W'(TONE_HALF - 1))
        begin
            nxt_tone_cnt = '0;
            nxt_tone = !tone_ff;
        end
        nxt_prev = op_state;
        // Chirp counter loads on the edge the transfer lamp pattern starts; the chirp reaches the red pin one edge later
        nxt_chirp_cnt = chirp_cnt_ff;
        if (in_transfer && prev_ff != OP_TRANSFER)
            nxt_chirp_cnt = CNT_W'(CHIRP_LEN);
        else if (!in_transfer)
            nxt_chirp_cnt = '0;
        else if (chirping)
            nxt_chirp_cnt = chirp_cnt_ff - 1'b1;
        // Beep cadence and 30 s phase timers, restarted on foreign warning entry
        nxt_beep_cnt = beep_cnt_ff + 1'b1;
        nxt_beep_on = beep_on_ff;
        nxt_phase_cnt = phase_cnt_ff + 1'b1;
        nxt_quiet = quiet_ff;
        if (!in_foreign)
        begin
            nxt_beep_cnt = '0;
            nxt_beep_on = 1'b1;
            nxt_phase_cnt = '0;
            nxt_quiet = 1'b0;
        end
        else
        begin
            if (beep_on_ff && beep_cnt_ff >= CNT_W'(CHIRP_LEN - 1))
            begin
                nxt_beep_cnt = '0;
                nxt_beep_on = 1'b0;
            end
            else if (!beep_on_ff && beep_cnt_ff >= CNT_W'(GAP_LEN - 1))
            begin
                nxt_beep_cnt = '0;
                nxt_beep_on = 1'b1;
            end
            if (phase_cnt_ff >= CNT_W'(PHASE_LEN - 1))
            begin
                nxt_phase_cnt = '0;
                nxt_quiet = !quiet_ff;
                nxt_beep_cnt = '0;
                nxt_beep_on = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            slow_cnt_ff <= '0;
            fast_cnt_ff <= '0;
            slow_ff <= 1'b0;
            fast_ff <= 1'b0;
            tone_cnt_ff <= '0;
            tone_ff <= 1'b0;
            chirp_cnt_ff <= '0;
            beep_cnt_ff <= '0;
            phase_cnt_ff <= '0;
            quiet_ff <= 1'b0;
            beep_on_ff <= 1'b1;
            prev_ff <= OP_STANDBY;
        end
        else
        begin
            slow_cnt_ff <= nxt_slow_cnt;
            fast_cnt_ff <= nxt_fast_cnt;
            slow_ff <= nxt_slow;
            fast_ff <= nxt_fast;
            tone_cnt_ff <= nxt_tone_cnt;
            tone_ff <= nxt_tone;
            chirp_cnt_ff <= nxt_chirp_cnt;
            beep_cnt_ff <= nxt_beep_cnt;
            phase_cnt_ff <= nxt_phase_cnt;
            quiet_ff <= nxt_quiet;
            beep_on_ff <= nxt_beep_on;
            prev_ff <= nxt_prev;
        end
    end

    // ------------------------------------------------------------
    // Lamp and pin decode
    // ------------------------------------------------------------
    lbi_pins_t nxt_pins;
    logic [1:0] route_ff, nxt_route;
    logic standby_lit;

    // Reserved codes keep the pattern of their group; zero counts as lit
    assign standby_lit = (opt_ff < OPT_FIRST_DARK);

    always_comb
    begin
        nxt_pins = '0;
        nxt_route = adc_route_sel;
        unique case (op_state)
            OP_STANDBY:
            begin
                nxt_pins.green_drive = standby_lit;
                nxt_pins.red_drive = standby_lit;
            end
            OP_TRANSFER:
            begin
                nxt_pins.green_drive = slow_ff;
                nxt_pins.red_drive = chirping && tone_ff;
            end
            OP_COMPLETE:
            begin
                nxt_pins.green_drive = 1'b1;
                nxt_pins.red_drive = 1'b0;
            end
            OP_FAULT:
            begin
                nxt_pins.green_drive = 1'b0;
                nxt_pins.red_drive = 1'b1;
            end
            OP_FOREIGN_WARN:
            begin
                nxt_pins.green_drive = 1'b0;
                // Tone carrier rides on the lit red lamp; quiet phase just blinks
                if (quiet_ff)
                    nxt_pins.red_drive = fast_ff;
                else
                    nxt_pins.red_drive = foreign_tone && tone_ff;
            end
            default:
            begin
                nxt_pins = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            route_ff <= '0;
        end
        else
        begin
            route_ff <= nxt_route;
        end
    end

    // ------------------------------------------------------------
    // Open-drain pin drivers
    // ------------------------------------------------------------
    // Enable low pulls the pin low and lights the lamp; data stays low so a
    // released pin is left to its pull-up and never fights it
    logic green_oe_n_ff, nxt_green_oe_n;
    logic red_oe_n_ff, nxt_red_oe_n;
    logic [1:0] data_ff, nxt_data;

    always_comb
    begin
        nxt_green_oe_n = !nxt_pins.green_drive;
        nxt_red_oe_n = !nxt_pins.red_drive;
        nxt_data = 2'h0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            green_oe_n_ff <= 1'b1;
            red_oe_n_ff <= 1'b1;
            data_ff <= 2'h0;
        end
        else
        begin
            green_oe_n_ff <= nxt_green_oe_n;
            red_oe_n_ff <= nxt_red_oe_n;
            data_ff <= nxt_data;
        end
    end

    assign green_indicator_pin_o = data_ff[0];
    assign red_indicator_buzzer_pin_o = data_ff[1];
    assign green_indicator_pin_oe_n = green_oe_n_ff;
    assign red_indicator_buzzer_pin_oe_n = red_oe_n_ff;
    assign green_adc_route = route_ff[0];
    assign red_adc_route = route_ff[1];
    assign option_latched = opt_ff;
    assign option_done = done_ff;

endmodule
`default_nettype wire

// File: verification/lbi_indicator_sva.sv
// Checker: decode and cadence assertions on the indicator ports
`timescale 1ns/1ps
`default_nettype none
module lbi_indicator_sva
    import lbi_pkg::*;
#(
    parameter int CHIRP_LEN = 20,
    parameter int GAP_LEN = 40,
    parameter int PHASE_LEN = 300
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire lbi_op_t op_state,
    input wire logic [3:0] option_code,
    input wire logic option_valid,
    input wire logic [1:0] adc_route_sel,
    input wire logic green_indicator_pin_oe_n,
    input wire logic red_indicator_buzzer_pin_oe_n,
    input wire logic green_adc_route,
    input wire logic red_adc_route,
    input wire logic [3:0] option_latched,
    input wire logic option_done
);
    // ----------------------------------------
    // Time spent in the current state
    // ----------------------------------------
    lbi_op_t st_ff, nxt_st;
    int cnt_ff, nxt_cnt, pos;
    logic g, r, in_tone;
    assign g = green_indicator_pin_oe_n;
    assign r = red_indicator_buzzer_pin_oe_n;
    // Margins of a few cycles absorb the one-edge decode delay
    always_comb
    begin
        nxt_st = op_state;
        nxt_cnt = cnt_ff + 1;
        if (!rst_n || op_state != st_ff || cnt_ff == 2 * PHASE_LEN - 1)
        begin
            nxt_cnt = 0;
        end
        pos = cnt_ff % (CHIRP_LEN + GAP_LEN);
        in_tone = pos >= 3 && pos < CHIRP_LEN - 4
            && ((st_ff == OP_FOREIGN_WARN && cnt_ff < PHASE_LEN)
            || (st_ff == OP_TRANSFER && cnt_ff < CHIRP_LEN));
    end
    always_ff @(posedge sys_clk)
    begin
        st_ff <= nxt_st;
        cnt_ff <= nxt_cnt;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Half wave fixed at two cycles, the bench's tone setting
    sequence half_wave;
        $stable(r) ##1 $changed(r);
    endsequence
    sequence tone_edge;
        $changed(r);
    endsequence
    rst_vals_a: assert property (disable iff (1'b0)
        !rst_n |=> g && r && !option_done && option_latched == 4'h1 && !green_adc_route)
        else $error("reset values wrong");
    opt_take_a: assert property (
        option_valid && !option_done |=> option_done && option_latched == $past(option_code))
        else $error("option not taken");
    opt_hold_a: assert property (
        option_done |=> option_done && $stable(option_latched))
        else $error("option changed");
    adc_route_a: assert property (
        $past(rst_n) |-> {red_adc_route, green_adc_route} == $past(adc_route_sel))
        else $error("route wrong");
    standby_lit_a: assert property (
        $past(rst_n) && $past(option_done) && $past(op_state) == OP_STANDBY
        && option_latched < 4'h6 |-> !g && !r) else $error("standby not lit");
    standby_dark_a: assert property (
        $past(rst_n) && $past(option_done) && $past(op_state) == OP_STANDBY
        && option_latched >= 4'h6 |-> g && r) else $error("standby not dark");
    tone_rate_a: assert property (
        in_tone && $changed(r) |=> half_wave) else $error("tone rate wrong");
    tone_start_a: assert property (
        in_tone |-> ##[0:1] tone_edge) else $error("tone missing");
    foreign_gap_a: assert property (
        st_ff == OP_FOREIGN_WARN && cnt_ff < PHASE_LEN && pos >= CHIRP_LEN + 3
        && pos < CHIRP_LEN + GAP_LEN - 3 |-> g && r) else $error("gap not silent");
    quiet_blink_a: assert property (
        st_ff == OP_FOREIGN_WARN && cnt_ff >= PHASE_LEN + 8 && cnt_ff < 2 * PHASE_LEN - 8
        && $changed(r) |=> $stable(r) [*3]) else $error("quiet phase toned");
    post_chirp_a: assert property (
        st_ff == OP_TRANSFER && cnt_ff > CHIRP_LEN + 3 && cnt_ff < 500 |-> r)
        else $error("red on after chirp");
endmodule
`default_nettype wire

// File: verification/lbi_lamp_model.sv
// Model: open-drain pins with pull-ups driving the two lamps
`timescale 1ns/1ps
`default_nettype none
module lbi_lamp_model
(
    input wire logic green_o,
    input wire logic green_oe_n,
    input wire logic red_o,
    input wire logic red_oe_n,
    output logic green_lit,
    output logic red_lit
);
    wire logic green_wire;
    wire logic red_wire;
    // A released pin goes to the pull-up, so its lamp is dark
    assign green_wire = green_oe_n ? 1'b1 : green_o;
    assign red_wire = red_oe_n ? 1'b1 : red_o;
    assign green_lit = !green_wire;
    assign red_lit = !red_wire;
endmodule
`default_nettype wire

// File: verification/lbi_indicator_tb.sv
// Testbench: option, route, transfer and foreign object scenarios
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t got %h expected %h", $time, a, b); end end
module lbi_indicator_tb
    import lbi_pkg::*;
;
    localparam int CH = 20;
    localparam int PH = 300;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    lbi_op_t op_state = OP_STANDBY;
    logic [3:0] option_code = 4'h0;
    logic option_valid = 1'b0;
    logic [1:0] adc_route_sel = 2'h0;
    logic g_o, g_oe_n, r_o, r_oe_n, g_rt, r_rt, opt_done, g_lit, r_lit;
    logic [3:0] opt_q;
    int n_fail = 0;
    int samples_checked = 0;
    always #25 sys_clk = ~sys_clk;
    lbi_indicator #(.SLOW_HALF(6), .FAST_HALF(4), .CHIRP_LEN(CH), .GAP_LEN(40),
        .PHASE_LEN(PH), .TONE_HALF(2)) i_lbi_indicator (.sys_clk(sys_clk), .rst_n(rst_n),
        .op_state(op_state), .option_code(option_code), .option_valid(option_valid),
        .adc_route_sel(adc_route_sel), .green_indicator_pin_o(g_o),
        .green_indicator_pin_oe_n(g_oe_n), .red_indicator_buzzer_pin_o(r_o),
        .red_indicator_buzzer_pin_oe_n(r_oe_n), .green_adc_route(g_rt),
        .red_adc_route(r_rt), .option_latched(opt_q), .option_done(opt_done));
    lbi_lamp_model i_lbi_lamp_model (.green_o(g_o), .green_oe_n(g_oe_n), .red_o(r_o),
        .red_oe_n(r_oe_n), .green_lit(g_lit), .red_lit(r_lit));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic count_lamp(input logic grn, input int n, output int k);
        logic last;
        k = 0;
        last = grn ? g_lit : r_lit;
        repeat (n)
        begin
            @(negedge sys_clk);
            k += int'((grn ? g_lit : r_lit) != last);
            last = grn ? g_lit : r_lit;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_option;
        for (int c = 1; c <= 10; c++)
        begin
            rst_n = 1'b0;
            cycles(3);
            rst_n = 1'b1;
            `CHK({opt_done, opt_q, g_lit, r_lit, g_rt}, 8'h08)
            cycles(1);
            `CHK({g_lit, r_lit}, 2'b11)
            option_code = 4'(c);
            option_valid = 1'b1;
            cycles(1);
            // A later valid with another code must be refused
            option_code = 4'h7 ^ 4'(c);
            cycles(3);
            option_valid = 1'b0;
            `CHK({opt_done, opt_q}, {1'b1, 4'(c)})
            `CHK({g_lit, r_lit}, {2{c < 6}})
        end
    endtask
    task automatic t_route;
        for (int s = 0; s < 4; s++)
        begin
            adc_route_sel = 2'(s);
            cycles(1);
            `CHK({r_rt, g_rt, g_o, r_o}, {2'(s), 2'b00})
        end
    endtask
    task automatic t_xfer;
        int k;
        op_state = OP_TRANSFER;
        count_lamp(1'b0, CH, k);
        `CHK(k inside {[9:11]}, 1'b1)
        count_lamp(1'b0, 30, k);
        `CHK({k, r_lit}, 33'h0)
        count_lamp(1'b1, 30, k);
        `CHK(k inside {[4:6]}, 1'b1)
        op_state = OP_COMPLETE;
        cycles(2);
        `CHK({g_lit, r_lit}, 2'b10)
        op_state = OP_FAULT;
        cycles(2);
        `CHK({g_lit, r_lit}, 2'b01)
        op_state = OP_STANDBY;
        cycles(20);
        `CHK({g_lit, r_lit}, 2'b00)
    endtask
    task automatic t_foreign;
        int k;
        op_state = OP_FOREIGN_WARN;
        count_lamp(1'b0, PH, k);
        `CHK({k inside {[48:52]}, g_lit}, 2'b10)
        count_lamp(1'b0, PH, k);
        `CHK(k inside {[73:77]}, 1'b1)
        count_lamp(1'b0, 60, k);
        `CHK(k inside {[9:11]}, 1'b1)
        op_state = OP_STANDBY;
        cycles(2);
        count_lamp(1'b0, 20, k);
        `CHK({k, r_lit}, 33'h0)
    endtask
    initial
    begin
        t_option;
        t_route;
        t_xfer;
        t_foreign;
        tally_and_finish;
    end
    initial
    begin
        #200000;
        n_fail++;
        tally_and_finish;
    end
endmodule
bind lbi_indicator lbi_indicator_sva #(.CHIRP_LEN(CHIRP_LEN), .GAP_LEN(GAP_LEN),
    .PHASE_LEN(PHASE_LEN)) i_lbi_indicator_sva (.sys_clk(sys_clk), .rst_n(rst_n),
    .op_state(op_state), .option_code(option_code), .option_valid(option_valid),
    .adc_route_sel(adc_route_sel), .green_indicator_pin_oe_n(green_indicator_pin_oe_n),
    .red_indicator_buzzer_pin_oe_n(red_indicator_buzzer_pin_oe_n),
    .green_adc_route(green_adc_route), .red_adc_route(red_adc_route),
    .option_latched(option_latched), .option_done(option_done));
`default_nettype wire
